// ===== bench/dmr1_dram_test.sv
`include "dmr1_map.svh"
module dmr1_dram_test
    import dmr1_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic banks_idle = 1'b1;
    logic alo, alr, hiz, tst, wma, tra, wta, lvl;
    logic [3:0] rdf, wdf;
    logic [17:0] mr;
    dmr1_drv_t drv;
    dmr1_term_t trm;
    int miscompares = 0;
    int checks_done = 0;
    dmr1_link_if link ();
    always #2.5 core_clk = ~core_clk;
    dmr1_ctrl dmr1_ctrl_inst (.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .banks_idle(banks_idle), .link(link));
    dmr1_dram dmr1_dram_inst (.core_clk(core_clk), .rst_n(rst_n), .link(link), .is_x8(1'b1),
        .write_term_en(1'b1), .align_loop_on(alo), .align_loop_reset(alr), .drive_sel(drv),
        .outputs_hiz(hiz), .tstrobe_term(tst), .write_mask_active(wma), .term_sel(trm),
        .term_active(tra), .write_term_active(wta), .leveling(lvl), .read_delay_floor(rdf),
        .write_delay_floor(wdf), .mode_register_one(mr));
    dmr1_props dmr1_props_inst (.core_clk(core_clk), .rst_n(rst_n),
        .mode_set_command(link.mode_set_command), .bank(link.bank), .addr(link.addr),
        .self_refresh(link.self_refresh), .mode_register_one(mr), .align_loop_on(alo),
        .outputs_hiz(hiz), .leveling(lvl), .term_active(tra), .read_delay_floor(rdf));
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one avalon access, held until waitrequest low
    task automatic acc(input logic wr, input logic [3:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 50) begin
            miscompares++;
            report_and_stop();
        end
        @(posedge core_clk);
    endtask : acc
    task automatic load(input logic [31:0] v, input int stall, input logic x8);
        logic [31:0] q;
        int n;
        acc(1'b1, `DMR1_REG_CTRL, {28'h0, x8, 3'h0}, q);
        acc(1'b1, `DMR1_REG_DEV, v, q);
        banks_idle <= (stall == 0);
        acc(1'b1, `DMR1_REG_CTRL, {28'h0, x8, 3'h1}, q);
        repeat (stall) @(posedge core_clk);
        if (stall > 0) chk(mr, 32'h0);
        banks_idle <= 1'b1;
        n = 0;
        do begin
            acc(1'b0, `DMR1_REG_CTRL, 32'h0, q);
            n++;
        end while (q[2] !== 1'b0 && n < 40);
        chk(n < 40, 1'b1);
        if (n >= 40) begin
            report_and_stop();
        end
    endtask : load
    task automatic self_ref(input logic exp_on);
        logic [31:0] q;
        logic seen;
        acc(1'b1, `DMR1_REG_CTRL, 32'hA, q);
        repeat (3) @(posedge core_clk);
        chk(alo, 1'b0);
        acc(1'b1, `DMR1_REG_CTRL, 32'h8, q);
        seen = 1'b0;
        repeat (20) begin
            @(posedge core_clk);
            if (alr === 1'b1) seen = 1'b1;
        end
        chk(seen, exp_on);
        chk(alo, exp_on);
    endtask : self_ref
    task automatic t_fields;
        load(32'h27D86, 5, 1'b1);
        chk(mr, 32'h1886);
        chk(drv, DMR1_DRV_DIV7);
        chk(trm, DMR1_TERM_DIV4);
        chk({hiz, lvl, tst, wma}, 4'hE);
        chk(alo, 1'b1);
        self_ref(1'b1);
    endtask : t_fields
    task automatic t_loop_off;
        logic [31:0] q;
        load(32'h0A05, 0, 1'b0);
        chk(mr, 32'h0001);
        chk(mr[`DMR1_B_TSTROBE], 1'b0);
        chk({rdf, wdf}, 8'h66);
        chk({alo, wma}, 2'h1);
        self_ref(1'b0);
        acc(1'b0, 4'hC, 32'h0, q);
        chk(q, 32'h0);
    endtask : t_loop_off
    task automatic t_term;
        logic [31:0] q;
        load(32'h0280, 0, 1'b1);
        acc(1'b1, `DMR1_REG_CTRL, 32'h18, q);
        repeat (2) @(posedge core_clk);
        chk({tra, wta}, 2'h0);
        load(32'h0200, 0, 1'b1);
        acc(1'b1, `DMR1_REG_CTRL, 32'h18, q);
        repeat (2) @(posedge core_clk);
        chk({tra, wta}, 2'h2);
        acc(1'b1, `DMR1_REG_CTRL, 32'h38, q);
        repeat (2) @(posedge core_clk);
        chk({tra, wta}, 2'h1);
        acc(1'b1, `DMR1_REG_CTRL, 32'h8, q);
        repeat (2) @(posedge core_clk);
        chk({tra, wta}, 2'h0);
    endtask : t_term
    initial begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        chk(mr, 32'h0);
        t_fields();
        t_loop_off();
        t_term();
        report_and_stop();
    end
endmodule : dmr1_dram_test

// ===== bench/dmr1_props.sv
module dmr1_props (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // link
    input wire logic mode_set_command,
    input wire logic [2:0] bank,
    input wire logic [17:0] addr,
    input wire logic self_refresh,
    // device state
    input wire logic [17:0] mode_register_one,
    input wire logic align_loop_on,
    input wire logic outputs_hiz,
    input wire logic leveling,
    input wire logic term_active,
    input wire logic [3:0] read_delay_floor
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_load_takes_addr: assert property (
        mode_set_command && bank == 3'h1 |=> mode_register_one == $past(addr))
        else $error("mode register not loaded from address");
    a_hold_no_load: assert property (
        !(mode_set_command && bank == 3'h1) |=> $stable(mode_register_one))
        else $error("mode register changed without load");
    a_reserved_zero: assert property (
        mode_set_command |-> (addr & 18'h26500) == 18'h00000)
        else $error("reserved bits set in mode set");
    a_gap_after_load: assert property (
        mode_set_command |=> !mode_set_command [*8])
        else $error("mode set repeated inside gap");
    a_slow_delays: assert property (
        mode_register_one[0] |-> read_delay_floor == 4'h6)
        else $error("delay floor not six with loop off");
    a_hiz_follows_bit: assert property (
        outputs_hiz == mode_register_one[12])
        else $error("output disable mismatch");
    a_level_follows_bit: assert property (
        leveling == mode_register_one[7])
        else $error("leveling mismatch");
    a_no_term_loop_off: assert property (
        mode_register_one[0] |-> !term_active)
        else $error("termination active with loop off");
    a_loop_off_bit: assert property (
        mode_register_one[0] |-> !align_loop_on)
        else $error("loop on while disabled");
    a_loop_off_refresh: assert property (
        self_refresh ##1 self_refresh |-> !align_loop_on)
        else $error("loop on in self refresh");
endmodule : dmr1_props

// ===== rtl/dmr1_ctrl.sv
`include "dmr1_map.svh"
module dmr1_ctrl
    import dmr1_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // avalon slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // system status
    input wire logic banks_idle,
    // link
    dmr1_link_if.ctrl link
);
    typedef enum {C_IDLE, C_WAIT_IDLE, C_GAP} dmr1_cst_t;
    typedef struct packed {
        dmr1_cst_t fsm;
        logic [17:0] val;
        logic sr;
        logic x8;
        logic tpin;
        logic wb;
        logic msc;
        logic [7:0] gap;
        logic [31:0] rdata;
        logic wait_n;
    } dmr1_ctrl_st_t;

    dmr1_ctrl_st_t st;
    dmr1_ctrl_st_t next_st;
    logic [17:0] clean;

    always_comb begin
        next_st = st;
        next_st.msc = 1'b0;
        next_st.wait_n = 1'b0;
        // reserved zero; strobe only on x8; no term with loop off
        clean = avs_writedata[17:0] & ~`DMR1_RSVD_MASK;
        if (!st.x8) clean[`DMR1_B_TSTROBE] = 1'b0;
        if (clean[`DMR1_B_ALIGN_OFF]) begin
            clean[`DMR1_B_TERM2] = 1'b0;
            clean[`DMR1_B_TERM1] = 1'b0;
            clean[`DMR1_B_TERM0] = 1'b0;
        end
        // answer one cycle after the request is seen
        if ((avs_read || avs_write) && !st.wait_n) begin
            next_st.wait_n = 1'b1;
            next_st.rdata = 32'h0;
            if (avs_read) begin
                case (avs_address)
                    `DMR1_REG_DEV: next_st.rdata = {14'h0, st.val};
                    `DMR1_REG_CTRL: next_st.rdata = {26'h0, st.wb, st.tpin, st.x8,
                        st.fsm != C_IDLE, st.sr, 1'b0};
                    `DMR1_REG_STAT: next_st.rdata = {24'h0, st.gap};
                    default: next_st.rdata = 32'h0;
                endcase
            end
        end
        // writes land at the edge that completes the transfer
        if (avs_write && st.wait_n) begin
            case (avs_address)
                `DMR1_REG_DEV: next_st.val = clean;
                `DMR1_REG_CTRL: begin
                    next_st.sr = avs_writedata[`DMR1_CTRL_SR];
                    next_st.x8 = avs_writedata[`DMR1_CTRL_X8];
                    next_st.tpin = avs_writedata[`DMR1_CTRL_TERM];
                    next_st.wb = avs_writedata[`DMR1_CTRL_WBURST];
                    if (avs_writedata[`DMR1_CTRL_GO] && st.fsm == C_IDLE) begin
                        next_st.fsm = C_WAIT_IDLE;
                    end
                end
                default: ;
            endcase
        end
        case (st.fsm)
            C_WAIT_IDLE: if (banks_idle && !st.sr) begin
                next_st.msc = 1'b1;
                next_st.gap = 8'(`DMR1_UPD_GAP_CYC);
                next_st.fsm = C_GAP;
            end
            C_GAP: begin
                next_st.gap = st.gap - 8'h1;
                if (st.gap == 8'h1) next_st.fsm = C_IDLE;
            end
            default: ;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign avs_readdata = st.rdata;
    assign avs_waitrequest = !st.wait_n;
    assign link.mode_set_command = st.msc;
    assign link.bank = `DMR1_BANK_SEL;
    assign link.addr = st.val;
    assign link.self_refresh = st.sr;
    assign link.write_burst = st.wb;
    // no reads issued, pin never meets read data
    assign link.term_pin = st.tpin;
endmodule : dmr1_ctrl

// ===== rtl/dmr1_dram.sv
// Functional notes
// - register holds value until next load or reset
// - rewrite never touches array contents
// - load only with banks idle
// - controller waits both gaps after load; dmr1_ctrl counts only DMR1_UPD_GAP_CYC, DMR1_CMD_GAP_CYC is unused
// - controller writes reserved bits as zero
// - leveling limits termination unless outputs off
// - bit 0 enables or disables alignment loop
// - controller enables loop, then resets it; align_loop_reset pulses only on self-refresh exit
// - self refresh pauses, then resets loop
// - loop off stays off after self refresh
// - no termination while loop off
// - loop off forces delays to six
// - bits 5,1 select drive impedance
// - bit 12 tristates data and strobes
// - x8 strobe pair gets termination, no drive
// - strobe ball acts as mask when off
// - x4/x16 keep termination strobe off
// - bits 9,6,2 select nominal termination
// - termination off during read bursts
// - termination pin gates nominal termination
// - writes substitute write termination
// - bit 7 enters write leveling
`include "dmr1_map.svh"
module dmr1_dram
    import dmr1_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // link
    dmr1_link_if.dram link,
    // device configuration
    input wire logic is_x8,
    input wire logic write_term_en,
    // decoded controls
    output logic align_loop_on,
    output logic align_loop_reset,
    output dmr1_drv_t drive_sel,
    output logic outputs_hiz,
    output logic tstrobe_term,
    output logic write_mask_active,
    output dmr1_term_t term_sel,
    output logic term_active,
    output logic write_term_active,
    output logic leveling,
    output logic [3:0] read_delay_floor,
    output logic [3:0] write_delay_floor,
    output logic [17:0] mode_register_one
);
    typedef struct packed {
        logic [17:0] mr;
        logic x8_meta;
        logic x8_sync;
        logic wte_meta;
        logic wte_sync;
        logic sr_q;
        logic loop_paused;
        logic loop_on;
        logic loop_rst;
        dmr1_drv_t drive;
        logic hiz;
        logic tstrobe;
        logic wmask;
        dmr1_term_t code;
        logic term_on;
        logic wterm_on;
        logic level;
        logic [3:0] rd_floor;
        logic [3:0] wr_floor;
    } dmr1_dram_st_t;

    dmr1_dram_st_t st;
    dmr1_dram_st_t next_st;
    logic sr_enter;
    logic sr_exit;
    logic term_ok;
    logic wr_ok;

    always_comb begin
        next_st = st;
        next_st.loop_rst = 1'b0;
        next_st.sr_q = link.self_refresh;
        // strap inputs, two-stage sync
        next_st.x8_meta = is_x8;
        next_st.x8_sync = st.x8_meta;
        next_st.wte_meta = write_term_en;
        next_st.wte_sync = st.wte_meta;
        // self refresh edges
        sr_enter = link.self_refresh && !st.sr_q;
        sr_exit = !link.self_refresh && st.sr_q;

        if (link.mode_set_command && link.bank == `DMR1_BANK_SEL) begin
            next_st.mr = link.addr;
        end

        if (sr_enter && !next_st.mr[`DMR1_B_ALIGN_OFF]) begin
            next_st.loop_paused = 1'b1;
        end
        if (sr_exit && st.loop_paused) begin
            next_st.loop_paused = 1'b0;
            next_st.loop_rst = 1'b1;
        end
        // bit 0 low enables loop; off stays off
        next_st.loop_on = !next_st.mr[`DMR1_B_ALIGN_OFF] && !next_st.loop_paused;

        case ({next_st.mr[`DMR1_B_DRV1], next_st.mr[`DMR1_B_DRV0]})
            2'h1: next_st.drive = DMR1_DRV_DIV7;
            default: next_st.drive = DMR1_DRV_DIV6;
        endcase
        next_st.hiz = next_st.mr[`DMR1_B_QOFF];
        next_st.tstrobe = st.x8_sync && next_st.mr[`DMR1_B_TSTROBE];
        next_st.wmask = !next_st.tstrobe;
        next_st.level = next_st.mr[`DMR1_B_LEVEL];

        case ({next_st.mr[`DMR1_B_TERM2], next_st.mr[`DMR1_B_TERM1], next_st.mr[`DMR1_B_TERM0]})
            3'h1: next_st.code = DMR1_TERM_DIV4;
            3'h2: next_st.code = DMR1_TERM_DIV2;
            3'h3: next_st.code = DMR1_TERM_DIV6;
            3'h4: next_st.code = DMR1_TERM_DIV12;
            3'h5: next_st.code = DMR1_TERM_DIV8;
            default: next_st.code = DMR1_TERM_OFF;
        endcase

        if (next_st.mr[`DMR1_B_ALIGN_OFF]) begin
            next_st.rd_floor = `DMR1_SLOW_DELAY;
            next_st.wr_floor = `DMR1_SLOW_DELAY;
        end else begin
            next_st.rd_floor = 4'h0;
            next_st.wr_floor = 4'h0;
        end

        term_ok = next_st.code != DMR1_TERM_OFF && next_st.loop_on
            && !link.self_refresh;
        case (next_st.code)
            DMR1_TERM_DIV2, DMR1_TERM_DIV4, DMR1_TERM_DIV6: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
        if (next_st.level && !next_st.hiz && !wr_ok) begin
            term_ok = 1'b0;
        end
        next_st.wterm_on = link.term_pin && term_ok && st.wte_sync && link.write_burst
            && !next_st.level;
        next_st.term_on = link.term_pin && term_ok && !next_st.wterm_on;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            // decode of an all-zero register
            st.loop_on <= 1'b1;
            st.wmask <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // outputs, one flop each
    // loop status out
    assign align_loop_on = st.loop_on;
    assign align_loop_reset = st.loop_rst;

    assign drive_sel = st.drive;
    assign outputs_hiz = st.hiz;
    assign tstrobe_term = st.tstrobe;
    assign write_mask_active = st.wmask;

    assign term_sel = st.code;
    assign term_active = st.term_on;
    assign write_term_active = st.wterm_on;
    assign leveling = st.level;

    assign read_delay_floor = st.rd_floor;
    assign write_delay_floor = st.wr_floor;
    assign mode_register_one = st.mr;
endmodule : dmr1_dram

// ===== rtl/dmr1_link_if.sv
interface dmr1_link_if;
    logic mode_set_command;
    logic [2:0] bank;
    logic [17:0] addr;
    logic self_refresh;
    logic write_burst;
    logic term_pin;
    modport dram (
        input mode_set_command,
        input bank,
        input addr,
        input self_refresh,
        input write_burst,
        input term_pin
    );
    modport ctrl (
        output mode_set_command,
        output bank,
        output addr,
        output self_refresh,
        output write_burst,
        output term_pin
    );
endinterface : dmr1_link_if

// ===== rtl/dmr1_map.svh
`ifndef DMR1_MAP_SVH
`define DMR1_MAP_SVH
// mode-register address field
`define DMR1_ADDR_W 18
`define DMR1_BANK_W 3
`define DMR1_BANK_SEL 3'h1
`define DMR1_RESET_VAL 18'h00000
// field positions
`define DMR1_B_ALIGN_OFF 0
`define DMR1_B_DRV0 1
`define DMR1_B_TERM0 2
`define DMR1_B_POST0 3
`define DMR1_B_POST1 4
`define DMR1_B_DRV1 5
`define DMR1_B_TERM1 6
`define DMR1_B_LEVEL 7
`define DMR1_B_TERM2 9
`define DMR1_B_TSTROBE 11
`define DMR1_B_QOFF 12
`define DMR1_RSVD_MASK 18'h26500
// delays forced while the alignment loop is off
`define DMR1_SLOW_DELAY 4'h6
// timing gaps, in command clocks
`define DMR1_CMD_GAP_CYC 4
`define DMR1_UPD_GAP_CYC 12
// avalon map of the controller
`define DMR1_REG_CTRL 4'h0
`define DMR1_REG_STAT 4'h4
`define DMR1_REG_DEV 4'h8
`define DMR1_CTRL_GO 0
`define DMR1_CTRL_SR 1
`define DMR1_CTRL_BUSY 2
`define DMR1_CTRL_X8 3
`define DMR1_CTRL_TERM 4
`define DMR1_CTRL_WBURST 5
`endif

// ===== rtl/dmr1_pkg.sv
package dmr1_pkg;
    typedef enum logic [2:0] {
        DMR1_TERM_OFF = 3'h0,
        DMR1_TERM_DIV4 = 3'h1,
        DMR1_TERM_DIV2 = 3'h2,
        DMR1_TERM_DIV6 = 3'h3,
        DMR1_TERM_DIV12 = 3'h4,
        DMR1_TERM_DIV8 = 3'h5
    } dmr1_term_t;
    typedef enum logic [1:0] {
        DMR1_DRV_DIV6 = 2'h0,
        DMR1_DRV_DIV7 = 2'h1
    } dmr1_drv_t;
endpackage : dmr1_pkg
